// file: include/rspwm_pkg.sv
// Types shared by the PWM block
package rspwm_pkg;
  // APB slave phases
  typedef enum logic [2:0] {
    RSPWM_IDLE   = 3'b001,
    RSPWM_ACCESS = 3'b010,
    RSPWM_DONE   = 3'b100
  } rspwm_bus_t;
  typedef logic [15:0] rspwm_cnt_t;
endpackage

// file: include/rspwm_regs.svh
// Register offsets, field positions, encodings and reset values of the PWM block
`ifndef RSPWM_REGS_SVH
`define RSPWM_REGS_SVH

// ==========================================================================
// Register byte offsets (APB, one aligned word each)
`define RSPWM_OFF_RUN      12'h000
`define RSPWM_OFF_CTRL     12'h004
`define RSPWM_OFF_COUNTER  12'h008
`define RSPWM_OFF_PERIOD   12'h00C
`define RSPWM_OFF_DUTY1    12'h010
`define RSPWM_OFF_DUTY2    12'h014
`define RSPWM_OFF_DUTY3    12'h018
`define RSPWM_OFF_STATUS   12'h01C
`define RSPWM_OFF_IRQEN    12'h020
`define RSPWM_OFF_MODE     12'h024

// ==========================================================================
// Run register fields
`define RSPWM_RUN_BIT      0
`define RSPWM_STOPSEL_BIT  2

// Control register fields
`define RSPWM_SRC_LSB      0
`define RSPWM_CLR_LSB      3
`define RSPWM_NORMAL_PHASE_LEVEL_SELECT_BIT     6
`define RSPWM_COUNTER_PHASE_LEVEL_SELECT_BIT     7

// Mode register field
`define RSPWM_MODE_LSB     0

// Status / enable bits
`define RSPWM_ST_PERIOD    0
`define RSPWM_ST_DUTY1     1
`define RSPWM_ST_DUTY2     2
`define RSPWM_ST_DUTY3     3
`define RSPWM_ST_OVF       4
`define RSPWM_ST_W         5

// ==========================================================================
// Encodings
`define RSPWM_SRC_FASTOSC  3'h6
`define RSPWM_CLR_PERIOD   3'h1
`define RSPWM_CLR_DUTY1    3'h2
`define RSPWM_CLR_SYNC     3'h3
`define RSPWM_CLR_CREG     3'h5
`define RSPWM_CLR_DREG     3'h6
`define RSPWM_MODE_RSYNC   2'h1

// ==========================================================================
// Reset values
`define RSPWM_CTRL_RST     8'h00
`define RSPWM_PERIOD_RST   16'hFFFF
`define RSPWM_DUTY_RST     16'hFFFF
`define RSPWM_MODE_RST     2'h0

`endif

// file: sim/rspwm_chk.sv
// Port-level assertions for the PWM block
`timescale 1ns/1ns
`include "rspwm_regs.svh"
module rspwm_chk #(
  parameter int CNT_W = 16
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fastOscClock,
  input wire logic        fastOscEnable,
  input wire logic        phase1NormalPin,
  input wire logic        phase1InversePin,
  input wire logic        phase2NormalPin,
  input wire logic        phase2InversePin,
  input wire logic        phase3NormalPin,
  input wire logic        phase3InversePin,
  input wire logic        interruptRequestFlag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Bus answer shape
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_READY_SOON: assert property (psel && penable && !pready |-> ##[1:2] pready)
    else $error("pready late");
  AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  AST_UNMAPPED: assert property (pready && paddr > 12'h024 |-> pslverr && prdata == 32'h0)
    else $error("unmapped word accepted");
  AST_MAPPED: assert property (pready && paddr <= 12'h024 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped word refused");
  AST_STATUS_B5: assert property (pready && !pwrite &&
    paddr == `RSPWM_OFF_STATUS |-> prdata[5])
    else $error("status bit five not one");
  // ==========================================================================
  // Pins: never both gates of a leg active, all six high in the first cycle after reset
  AST_NO_OVERLAP: assert property ((phase1NormalPin | phase1InversePin) &&
    (phase2NormalPin | phase2InversePin) && (phase3NormalPin | phase3InversePin))
    else $error("normal and inverse both active");
  AST_RESET_HIGH: assert property (!$past(arst_n) |-> phase1NormalPin &&
    phase2NormalPin && phase3NormalPin && phase1InversePin && phase2InversePin &&
    phase3InversePin)
    else $error("pins not high after reset");
  // Main scenarios reached
  COV_ERR: cover property (pslverr);
  COV_ACTIVE: cover property ($fell(phase1NormalPin));
  COV_IRQ: cover property ($rose(interruptRequestFlag));
endmodule
bind rspwm_top rspwm_chk #(.CNT_W(CNT_W)) u_chk (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fastOscClock(fastOscClock),
  .fastOscEnable(fastOscEnable), .phase1NormalPin(phase1NormalPin),
  .phase1InversePin(phase1InversePin), .phase2NormalPin(phase2NormalPin),
  .phase2InversePin(phase2InversePin), .phase3NormalPin(phase3NormalPin),
  .phase3InversePin(phase3InversePin), .interruptRequestFlag(interruptRequestFlag));

// file: sim/rspwm_stage.sv
// Power stage model: on-time of each leg's gate drive
`timescale 1ns/1ns
module rspwm_stage (
  input  wire logic        clk,
  input  wire logic        measure,
  input  wire logic        n1,
  input  wire logic        n2,
  input  wire logic        n3,
  output logic      [15:0] act1,
  output logic      [15:0] act2,
  output logic      [15:0] act3
);
  // Gate drive is active low; window restarts whenever measure drops
  always_ff @(posedge clk) begin
    if (!measure) begin
      act1 <= 16'h0000;
      act2 <= 16'h0000;
      act3 <= 16'h0000;
    end else begin
      act1 <= act1 + {15'h0000, ~n1};
      act2 <= act2 + {15'h0000, ~n2};
      act3 <= act3 + {15'h0000, ~n3};
    end
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for the three-phase PWM block
`timescale 1ns/1ns
`include "rspwm_regs.svh"
module tb;
  import rspwm_pkg::*;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, osc = 0, oscEn = 0, irq, meas = 0, e;
  logic        n1, i1, n2, i2, n3, i3;
  logic [5:0]  held;
  logic [15:0] a1, a2, a3;
  logic [2:0]  codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  rspwm_cnt_t  per, d1, d2, d3, c0;
  int          err_count = 0, checks_done = 0, cycles = 0, seed = 32'hB11448D7;
  // Main clock and an unrelated fast count source
  always #4 clk = ~clk;
  initial #3 forever #20 osc = ~osc;
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      complete_run();
    end
  end
  rspwm_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fastOscClock(osc), .fastOscEnable(oscEn), .phase1NormalPin(n1),
    .phase1InversePin(i1), .phase2NormalPin(n2), .phase2InversePin(i2),
    .phase3NormalPin(n3), .phase3InversePin(i3), .interruptRequestFlag(irq));
  rspwm_stage u_stage (.clk(clk), .measure(meas), .n1(n1), .n2(n2), .n3(n3),
    .act1(a1), .act2(a2), .act3(a3));
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e  = pslverr;
    check(n < 20, "no pready");
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check((rd & m) === x && e === 1'b0, "read mismatch");
  endtask
  // Expected counter bound for each clear source
  function automatic logic clr_ok(input logic [2:0] c, input logic [15:0] v);
    case (c)
      3'h1: return v <= per;
      3'h2: return v <= d1;
      default: return v > per;
    endcase
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // Reset values, mode entry and an unmapped word
    for (int k = 0; k < 4; k++) rdc(`RSPWM_OFF_PERIOD + 12'(4 * k), 32'hFFFF, 32'hFFFF);
    rdc(`RSPWM_OFF_CTRL, 32'hFF, 32'h0);
    rdc(`RSPWM_OFF_MODE, 32'h3, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    check(e === 1'b1 && rd === 32'h0, "unmapped word");
    wr(`RSPWM_OFF_MODE, 32'h0);
    wr(`RSPWM_OFF_MODE, 32'h1);
    rdc(`RSPWM_OFF_MODE, 32'h3, 32'h1);
    $display("test setup done");
    // Random period and duties, continuous run
    per = 16'(8 + $unsigned($random(seed)) % 8);
    d1 = 16'($unsigned($random(seed)) % per);
    d2 = 16'($unsigned($random(seed)) % per);
    d3 = 16'($unsigned($random(seed)) % per);
    wr(`RSPWM_OFF_PERIOD, {16'h0, per});
    wr(`RSPWM_OFF_DUTY1, {16'h0, d1});
    wr(`RSPWM_OFF_DUTY2, {16'h0, d2});
    wr(`RSPWM_OFF_DUTY3, {16'h0, d3});
    wr(`RSPWM_OFF_CTRL, 32'h08);
    wr(`RSPWM_OFF_COUNTER, 32'h0);
    wr(`RSPWM_OFF_RUN, 32'h4);
    wr(`RSPWM_OFF_RUN, 32'h5);
    repeat (2 * per + 4) @(posedge clk);
    meas <= 1'b1;
    repeat (per + 1) @(posedge clk);
    meas <= 1'b0;
    @(posedge clk);
    check(a1 === per - d1, "phase one duty");
    check(a2 === per - d2, "phase two duty");
    check(a3 === per - d3, "phase three duty");
    // Immediate stop holds pins and counter
    wr(`RSPWM_OFF_RUN, 32'h4);
    held = {n1, i1, n2, i2, n3, i3};
    apb(1'b0, `RSPWM_OFF_COUNTER, 32'h0);
    c0 = rd[15:0];
    repeat (per + 3) @(posedge clk);
    check({n1, i1, n2, i2, n3, i3} === held, "pins moved after stop");
    rdc(`RSPWM_OFF_COUNTER, 32'hFFFF, {16'h0, c0});
    $display("test waveform done");
    // Combined write and run clear with stop select 0
    wr(`RSPWM_OFF_PERIOD, 32'hC8);
    wr(`RSPWM_OFF_RUN, 32'h1);
    wr(`RSPWM_OFF_RUN, 32'h4);
    rdc(`RSPWM_OFF_RUN, 32'h1, 32'h1);
    wr(`RSPWM_OFF_RUN, 32'h1);
    wr(`RSPWM_OFF_RUN, 32'h0);
    rdc(`RSPWM_OFF_RUN, 32'h1, 32'h1);
    repeat (220) @(posedge clk);
    rdc(`RSPWM_OFF_RUN, 32'h1, 32'h0);
    rdc(`RSPWM_OFF_COUNTER, 32'hFFFF, 32'h0);
    check({n1, n2, n3, i1, i2, i3} === 6'b111000, "levels after period stop");
    wr(`RSPWM_OFF_CTRL, 32'hC8);
    check({n1, n2, n3, i1, i2, i3} === 6'b000111, "level select one");
    $display("test stop done");
    // Each of the five encoded clear source codes
    wr(`RSPWM_OFF_PERIOD, {16'h0, per});
    foreach (codes[k]) begin
      wr(`RSPWM_OFF_RUN, 32'h4);
      wr(`RSPWM_OFF_CTRL, {26'h0, codes[k], 3'h0});
      wr(`RSPWM_OFF_COUNTER, 32'h0);
      wr(`RSPWM_OFF_RUN, 32'h5);
      repeat (40) @(posedge clk);
      wr(`RSPWM_OFF_RUN, 32'h4);
      apb(1'b0, `RSPWM_OFF_COUNTER, 32'h0);
      check(clr_ok(codes[k], rd[15:0]), "clear source");
    end
    $display("test clear done");
    // Fast oscillator as count source
    wr(`RSPWM_OFF_PERIOD, 32'hFFFF);
    wr(`RSPWM_OFF_CTRL, 32'h0E);
    wr(`RSPWM_OFF_COUNTER, 32'h0);
    wr(`RSPWM_OFF_RUN, 32'h5);
    repeat (50) @(posedge clk);
    rdc(`RSPWM_OFF_COUNTER, 32'hFFFF, 32'h0);
    oscEn <= 1'b1;
    repeat (100) @(posedge clk);
    wr(`RSPWM_OFF_RUN, 32'h4);
    apb(1'b0, `RSPWM_OFF_COUNTER, 32'h0);
    check(rd[15:0] > 16'hA && rd[15:0] < 16'h28, "fast source rate");
    wr(`RSPWM_OFF_CTRL, 32'h08);
    repeat (2) @(posedge clk);
    oscEn <= 1'b0;
    // Counter write timed to land on the period clear at count 4
    wr(`RSPWM_OFF_PERIOD, 32'h4);
    wr(`RSPWM_OFF_COUNTER, 32'h0);
    rdc(`RSPWM_OFF_COUNTER, 32'hFFFF, 32'h0);
    wr(`RSPWM_OFF_RUN, 32'h5);
    wr(`RSPWM_OFF_COUNTER, 32'h1234);
    wr(`RSPWM_OFF_RUN, 32'h4);
    apb(1'b0, `RSPWM_OFF_COUNTER, 32'h0);
    check(rd[15:0] <= 16'h4, "write beat the clear");
    $display("test source done");
    // Status flags and request
    wr(`RSPWM_OFF_PERIOD, {16'h0, per});
    wr(`RSPWM_OFF_COUNTER, 32'h0);
    wr(`RSPWM_OFF_IRQEN, 32'h1);
    wr(`RSPWM_OFF_RUN, 32'h5);
    repeat (per + 4) @(posedge clk);
    wr(`RSPWM_OFF_RUN, 32'h4);
    check(irq === 1'b1, "request missing");
    wr(`RSPWM_OFF_STATUS, 32'h0);
    wr(`RSPWM_OFF_STATUS, 32'h1);
    check(irq === 1'b1, "flag cleared without read");
    wr(`RSPWM_OFF_IRQEN, 32'h0);
    repeat (2) @(posedge clk);
    check(irq === 1'b0, "masked request");
    wr(`RSPWM_OFF_IRQEN, 32'h1);
    rdc(`RSPWM_OFF_STATUS, 32'h1, 32'h1);
    check(irq === 1'b1, "request not back");
    wr(`RSPWM_OFF_STATUS, 32'h0);
    repeat (2) @(posedge clk);
    check(irq === 1'b0, "request after clear");
    rdc(`RSPWM_OFF_STATUS, 32'h1, 32'h0);
    $display("test status done");
    complete_run();
  end
endmodule

// file: verilog/rspwm_phase.sv
// One PWM phase: normal output and its inverse
`timescale 1ns/1ns
module rspwm_phase (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        tick,
  input  wire logic        restart,
  input  wire logic        dutyMatch,
  input  wire logic        periodMatch,
  input  wire logic        normLevel,
  input  wire logic        invLevel,
  output logic             normPin,
  output logic             invPin
);
  logic activeQ;

  // ==========================================================================
  // Phase state: active from duty match until period match
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      activeQ <= 1'b0;
    end else if (restart) begin
      activeQ <= 1'b0;                       // Inactive at count start, see [R19]
    end else if (tick && periodMatch) begin
      activeQ <= 1'b0;                       // see [R17]
    end else if (tick && dutyMatch) begin
      activeQ <= 1'b1;                       // see [R16] [R23]
    end
  end

  // Level select 0: inactive high, active low; inverse is complement
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      normPin <= 1'b1;
      invPin  <= 1'b1;
    end else begin
      normPin <= activeQ ? normLevel : ~normLevel;   // see [R19]
      invPin  <= activeQ ? ~invLevel : invLevel;     // see [R18]
    end
  end
endmodule

// file: verilog/rspwm_sync.sv
// Three-stage pin synchroniser with agreement check
`timescale 1ns/1ns
module rspwm_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================================
  // Stage chain; first stage read by second only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Change accepted only when stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncOut <= 1'b0;
    end else if (s2_q == s3_q) begin
      syncOut <= s3_q;
    end
  end
endmodule

// file: verilog/rspwm_top.sv
// Reset-synchronous three-phase PWM channel with APB register access
// Function
// [R1] Run clear ignored while stop select is 0
// [R2] Stop select 0: stop after period clear
// [R3] Stop select 1: run clear stops immediately
// [R4] Set stop select before clearing run bit
// [R5] Counter clear beats simultaneous software write
// [R6] Clear select codes pick the clear source
// [R7] Delay between counter write and read
// [R8] Delay between status write and read
// [R9] Change count source only while stopped
// [R10] Wait two main clocks before oscillator off
// [R11] Mode field 00b then 01b, then reprogram
// [R12] Use equal output level selects for motors
// [R13] Source code 110b selects fast oscillator
// [R14] Six outputs share one period
// [R15] Period is period register plus one
// [R16] Duty match drives normal output active
// [R17] Period match returns normal outputs inactive
// [R18] Inverse output complements normal output
// [R19] Level 0: start high, active low
// [R20] Flag clears on read 1 then write 0
// [R21] Request while flag and enable both set
// [R22] Counter increments per source tick while running
// [R23] Output change lands on next tick
`timescale 1ns/1ns
module rspwm_top #(
  parameter int CNT_W = 16
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      fastOscClock,
  input  wire logic                      fastOscEnable,
  output logic                           phase1NormalPin,
  output logic                           phase1InversePin,
  output logic                           phase2NormalPin,
  output logic                           phase2InversePin,
  output logic                           phase3NormalPin,
  output logic                           phase3InversePin,
  output logic                           interruptRequestFlag
);
  import rspwm_pkg::*;
`include "rspwm_regs.svh"

  // ==========================================================================
  // Register state
  logic             runBit_q;
  logic             stopSel_q;
  logic [7:0]       ctrl_q;
  logic [1:0]       mode_q;
  logic [CNT_W-1:0] counter_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] duty1_q;
  logic [CNT_W-1:0] duty2_q;
  logic [CNT_W-1:0] duty3_q;
  logic [4:0]       status_q;
  logic [4:0]       statusSeen_q;
  logic [4:0]       irqEn_q;
  logic             oscLevel_q;
  rspwm_bus_t       busState_q;

  logic             oscSync;
  logic             oscEnSync;
  logic             wrEn;
  logic             rdEn;
  logic             tick;
  logic             restart;
  logic             periodHit;
  logic             duty1Hit;
  logic             duty2Hit;
  logic             duty3Hit;
  logic             clearHit;
  logic             wrCounter;
  logic [2:0]       srcSel;
  logic [2:0]       clrSel;
  logic [31:0]      rdData;
  logic             addrOk;

  assign srcSel = ctrl_q[`RSPWM_SRC_LSB +: 3];
  assign clrSel = ctrl_q[`RSPWM_CLR_LSB +: 3];

  // ==========================================================================
  // Fast oscillator arrives from outside; sampled, its rising edge is a tick
  rspwm_sync u_oscSync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn (fastOscClock),
    .syncOut (oscSync)
  );

  // Oscillator enable is also foreign; an idle oscillator gives no ticks
  rspwm_sync u_oscEnSync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn (fastOscEnable),
    .syncOut (oscEnSync)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oscLevel_q <= 1'b0;
    end else begin
      oscLevel_q <= oscSync;
    end
  end

  // Main clock ticks every cycle; fast source ticks on sampled rising edge.
  // Sampling limits the usable oscillator rate to well below clk / 2.
  always_comb begin
    if (srcSel == `RSPWM_SRC_FASTOSC) begin
      tick = runBit_q & oscEnSync & oscSync & ~oscLevel_q;   // see [R13]
    end else begin
      tick = runBit_q;                                       // see [R22]
    end
  end

  // ==========================================================================
  // Compare matches
  assign periodHit = (counter_q == period_q);
  assign duty1Hit  = (counter_q == duty1_q);
  assign duty2Hit  = (counter_q == duty2_q);
  assign duty3Hit  = (counter_q == duty3_q);

  // Clear source decode; other codes never clear the counter
  always_comb begin
    case (clrSel)
      `RSPWM_CLR_PERIOD: clearHit = periodHit;   // see [R6] [R15]
      `RSPWM_CLR_DUTY1:  clearHit = duty1Hit;    // see [R6]
      `RSPWM_CLR_SYNC:   clearHit = 1'b0;        // No partner channel to sync
      `RSPWM_CLR_CREG:   clearHit = 1'b0;        // C and D registers unused here
      `RSPWM_CLR_DREG:   clearHit = 1'b0;
      default:           clearHit = 1'b0;
    endcase
  end

  // ==========================================================================
  // APB slave: setup, two wait cycles, then ready
  assign wrEn = (busState_q == RSPWM_ACCESS) & psel & penable & pwrite;
  assign rdEn = (busState_q == RSPWM_ACCESS) & psel & penable & ~pwrite;
  assign wrCounter = wrEn & (paddr == `RSPWM_OFF_COUNTER);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busState_q <= RSPWM_IDLE;
    end else begin
      case (busState_q)
        RSPWM_IDLE:   busState_q <= (psel && penable) ? RSPWM_ACCESS : RSPWM_IDLE;
        RSPWM_ACCESS: busState_q <= RSPWM_DONE;
        RSPWM_DONE:   busState_q <= RSPWM_IDLE;
        default:      busState_q <= RSPWM_IDLE;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero with an error
  always_comb begin
    rdData = 32'h0000_0000;
    addrOk = 1'b1;
    case (paddr)
      `RSPWM_OFF_RUN:     rdData = {29'h0, stopSel_q, 1'b0, runBit_q};
      `RSPWM_OFF_CTRL:    rdData = {24'h0, ctrl_q};
      `RSPWM_OFF_COUNTER: rdData = 32'(counter_q);
      `RSPWM_OFF_PERIOD:  rdData = 32'(period_q);
      `RSPWM_OFF_DUTY1:   rdData = 32'(duty1_q);
      `RSPWM_OFF_DUTY2:   rdData = 32'(duty2_q);
      `RSPWM_OFF_DUTY3:   rdData = 32'(duty3_q);
      `RSPWM_OFF_STATUS:  rdData = {26'h0, 1'b1, status_q};  // Bit 5 reads as one
      `RSPWM_OFF_IRQEN:   rdData = {27'h0, irqEn_q};
      `RSPWM_OFF_MODE:    rdData = {30'h0, mode_q};
      default:            addrOk = 1'b0;
    endcase
  end

  // Answer registered so outputs come from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= (busState_q == RSPWM_ACCESS) & psel & penable;
      pslverr <= (busState_q == RSPWM_ACCESS) & psel & penable & ~addrOk;
      prdata  <= rdEn ? rdData : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Run and stop-select bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      runBit_q  <= 1'b0;
      stopSel_q <= 1'b0;
    end else begin
      if (wrEn && paddr == `RSPWM_OFF_RUN) begin
        stopSel_q <= pwdata[`RSPWM_STOPSEL_BIT];
      end
      // A run-register write with the run bit 0 must not swallow a coinciding period stop
      if (wrEn && paddr == `RSPWM_OFF_RUN && pwdata[`RSPWM_RUN_BIT]) begin
        runBit_q <= 1'b1;
      end else if (wrEn && paddr == `RSPWM_OFF_RUN && stopSel_q) begin
        runBit_q <= 1'b0;   // Old select value decides, see [R3] [R4]
      end else if (!stopSel_q && tick && clearHit) begin
        runBit_q <= 1'b0;   // Stop after the period clear, see [R2]
      end                   // Select 0 ignores a run clear, see [R1]
    end
  end

  // Restart lands with the run bit, so a duty match at the first count is kept
  assign restart = wrEn && paddr == `RSPWM_OFF_RUN && pwdata[`RSPWM_RUN_BIT] && !runBit_q;

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q   <= `RSPWM_CTRL_RST;
      mode_q   <= `RSPWM_MODE_RST;
      period_q <= `RSPWM_PERIOD_RST;
      duty1_q  <= `RSPWM_DUTY_RST;
      duty2_q  <= `RSPWM_DUTY_RST;
      duty3_q  <= `RSPWM_DUTY_RST;
      irqEn_q  <= 5'h00;
    end else if (wrEn) begin
      case (paddr)
        `RSPWM_OFF_CTRL:   ctrl_q   <= pwdata[7:0];
        `RSPWM_OFF_MODE:   mode_q   <= pwdata[`RSPWM_MODE_LSB +: 2];
        `RSPWM_OFF_PERIOD: period_q <= pwdata[CNT_W-1:0];
        `RSPWM_OFF_DUTY1:  duty1_q  <= pwdata[CNT_W-1:0];
        `RSPWM_OFF_DUTY2:  duty2_q  <= pwdata[CNT_W-1:0];
        `RSPWM_OFF_DUTY3:  duty3_q  <= pwdata[CNT_W-1:0];
        `RSPWM_OFF_IRQEN:  irqEn_q  <= pwdata[4:0];
        default:           irqEn_q  <= irqEn_q;
      endcase
    end
  end

  // ==========================================================================
  // Counter: clear beats a coinciding write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_q <= '0;
    end else if (tick && clearHit) begin
      counter_q <= '0;                          // see [R5] [R15]
    end else if (wrCounter) begin
      counter_q <= pwdata[CNT_W-1:0];
    end else if (tick) begin
      counter_q <= counter_q + CNT_W'(1);       // see [R22]
    end
  end

  // ==========================================================================
  // Status flags: set wins; clear needs a prior read of one then write zero
  logic [4:0] events;
  assign events = {tick & (&counter_q), tick & duty3Hit, tick & duty2Hit,
                   tick & duty1Hit, tick & periodHit};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q     <= 5'h00;
      statusSeen_q <= 5'h00;
    end else begin
      if (rdEn && paddr == `RSPWM_OFF_STATUS) begin
        statusSeen_q <= status_q;
      end
      if (wrEn && paddr == `RSPWM_OFF_STATUS) begin
        status_q     <= (status_q & ~(statusSeen_q & ~pwdata[4:0])) | events;  // see [R20]
        statusSeen_q <= 5'h00;
      end else begin
        status_q <= status_q | events;
      end
    end
  end

  // Request level follows flag-and-enable pairs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interruptRequestFlag <= 1'b0;
    end else begin
      interruptRequestFlag <= |(status_q & irqEn_q);   // see [R21]
    end
  end

  // ==========================================================================
  // Three phases, one shared period compare; see [R14]
  rspwm_phase u_phase1 (
    .clk         (clk),
    .arst_n      (arst_n),
    .tick        (tick),
    .restart     (restart),
    .dutyMatch   (duty1Hit),
    .periodMatch (periodHit),
    .normLevel   (ctrl_q[`RSPWM_NORMAL_PHASE_LEVEL_SELECT_BIT]),
    .invLevel    (ctrl_q[`RSPWM_COUNTER_PHASE_LEVEL_SELECT_BIT]),
    .normPin     (phase1NormalPin),
    .invPin      (phase1InversePin)
  );

  rspwm_phase u_phase2 (
    .clk         (clk),
    .arst_n      (arst_n),
    .tick        (tick),
    .restart     (restart),
    .dutyMatch   (duty2Hit),
    .periodMatch (periodHit),
    .normLevel   (ctrl_q[`RSPWM_NORMAL_PHASE_LEVEL_SELECT_BIT]),
    .invLevel    (ctrl_q[`RSPWM_COUNTER_PHASE_LEVEL_SELECT_BIT]),
    .normPin     (phase2NormalPin),
    .invPin      (phase2InversePin)
  );

  rspwm_phase u_phase3 (
    .clk         (clk),
    .arst_n      (arst_n),
    .tick        (tick),
    .restart     (restart),
    .dutyMatch   (duty3Hit),
    .periodMatch (periodHit),
    .normLevel   (ctrl_q[`RSPWM_NORMAL_PHASE_LEVEL_SELECT_BIT]),
    .invLevel    (ctrl_q[`RSPWM_COUNTER_PHASE_LEVEL_SELECT_BIT]),
    .normPin     (phase3NormalPin),
    .invPin      (phase3InversePin)
  );
endmodule
